// ### verilog/osp_dev.sv
// Peripheral end: word store with zero-wait reads plus buffered stream ports.
`timescale 1ns/10ps

// Two-entry buffer; the drain side can stall and the fill side sees full.
module osp_fifo2 #(
    parameter int W = 32
) (
    input  wire logic         i_clock,
    input  wire logic         i_reset_n,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic [W-1:0]      o_out_data
);
    logic [1:0]   count_ff;
    logic [W-1:0] d0_ff;
    logic [W-1:0] d1_ff;
    logic         in_ready_ff;
    logic         out_valid_ff;

    // Handshake qualifiers and fill state; empty and full come from the flag flops.
    wire push  = i_in_valid && in_ready_ff;
    wire pop   = out_valid_ff && i_out_ready;
    wire empty = !out_valid_ff;
    wire one   = (count_ff == 2'h1);
    wire full  = !in_ready_ff;

    // Head refills from the second slot, or from the input when that is empty.
    wire [W-1:0] nxt_d0 = (pop || empty) ? (full ? d1_ff : i_in_data) : d0_ff;
    wire [W-1:0] nxt_d1 = (push && one && !pop) ? i_in_data : d1_ff;
    wire [1:0]   nxt_count = count_ff + {1'b0, push} - {1'b0, pop};

    // Ready and valid leave the buffer straight from flops, with no gate path
    // to the user; they are worked out one cycle ahead from the next fill level.
    assign o_in_ready  = in_ready_ff;
    assign o_out_valid = out_valid_ff;
    assign o_out_data  = d0_ff;

    // Storage, fill level and the two handshake flags.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count_ff     <= 2'h0;
            d0_ff        <= '0;
            d1_ff        <= '0;
            in_ready_ff  <= 1'b1;
            out_valid_ff <= 1'b0;
        end else begin
            count_ff     <= nxt_count;
            d0_ff        <= nxt_d0;
            d1_ff        <= nxt_d1;
            in_ready_ff  <= (nxt_count != 2'h2);
            out_valid_ff <= (nxt_count != 2'h0);
        end
    end
endmodule

module osp_dev
    import osp_pkg::*;
#(
    parameter int MEM_DEPTH = OSP_MEM_DEPTH
) (
    input  wire logic              i_clock,
    input  wire logic              i_reset_n,
    osp_bus_if.dev                 bus,
    output logic                   o_rx_valid,
    input  wire logic              i_rx_ready,
    output logic [OSP_DW-1:0]      o_rx_data,
    input  wire logic              i_tx_valid,
    output logic                   o_tx_ready,
    input  wire logic [OSP_DW-1:0] i_tx_data,
    input  wire logic              i_tx_last,
    input  wire logic              i_reset_ask
);
    // Word store, status flops and the links to the two stream buffers.
    logic [OSP_DW-1:0] mem_ff [MEM_DEPTH];
    logic              irq_ff;
    logic              reset_ask_ff;
    logic [OSP_DW-1:0] wr_word;
    logic              rx_in_ready;
    logic              tx_valid;
    logic [OSP_DW:0]   tx_head;

    // Address decode; nothing acts without slave select.
    // Writes outside the store and the stream port are dropped, while reads there
    // alias the store, because only the low index bits pick the word.
    wire [OSP_MEM_IW-1:0] mem_idx = bus.addr[OSP_MEM_IW-1:0];
    wire stream_hit = (bus.addr == OSP_STREAM_ADDR);
    wire mem_hit    = (bus.addr[OSP_AW-1:OSP_MEM_IW] == '0);
    wire rd_on      = bus.cs && (bus.read_n == OSP_ON_LOW);
    wire wr_on      = bus.cs && (bus.write_n == OSP_ON_LOW);

    // Each selected cycle is one transfer; strobe edges are never looked for,
    // since select and strobe may stay asserted into the next transfer.
    wire mem_we     = wr_on && mem_hit;
    wire rx_push    = wr_on && stream_hit;
    wire tx_pop     = rd_on && stream_hit;

    // A stream write that finds the buffer full is stalled, not dropped.
    assign bus.stall = rx_push && !rx_in_ready;

    // Zero-wait read: the word follows the address with no clock, so
    // the store must stay flops; a registered output would need a wait state.
    // The read thus completes on the very next edge, with no wait state.
    assign bus.rdata = stream_hit ? tx_head[OSP_DW-1:0] : mem_ff[mem_idx];

    // This slave has fixed zero latency, so the return strobe stays idle.
    assign bus.rdata_valid  = OSP_RDV_IDLE;
    assign bus.sink_ready   = rx_in_ready;
    assign bus.source_avail = tx_valid;
    assign bus.pkt_last     = tx_valid && tx_head[OSP_DW];
    assign bus.irq          = irq_ff;
    assign bus.reset_ask    = reset_ask_ff;

    // Merge enabled byte lanes into the stored word.
    // Lanes left off keep their stored byte; reads ignore the mask entirely.
    always_comb begin
        wr_word = mem_ff[mem_idx];
        for (int i = 0; i < OSP_LANES; i++) begin
            if (bus.lane_mask_low[i] == OSP_ON_LOW) begin
                wr_word[i*OSP_BYTE_W +: OSP_BYTE_W] = bus.wdata[i*OSP_BYTE_W +: OSP_BYTE_W];
            end
        end
    end

    // Word store, written on the edge that ends a selected write.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_ff[i] <= OSP_WORD_RST;
            end
        end else if (mem_we) begin
            mem_ff[mem_idx] <= wr_word;
        end
    end

    // Service request while outbound stream words wait to be read.
    // Registering it keeps the line free of glitches at the cost of one cycle.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= tx_valid;
        end
    end

    // The user's system reset request, registered once.
    // The level passes through unchanged; stretching it is left to the user.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            reset_ask_ff <= 1'b0;
        end else begin
            reset_ask_ff <= i_reset_ask;
        end
    end

    // Inbound stream: bus writes fill, the user drains and may stall.
    // Two entries let a word arrive in the cycle the user drains one, so a
    // user that keeps pace never causes a stall on the bus.
    osp_fifo2 #(
        .W (OSP_DW)
    ) u_rx_buf (
        .i_clock     (i_clock),
        .i_reset_n   (i_reset_n),
        .i_in_valid  (rx_push),
        .o_in_ready  (rx_in_ready),
        .i_in_data   (bus.wdata),
        .o_out_valid (o_rx_valid),
        .i_out_ready (i_rx_ready),
        .o_out_data  (o_rx_data)
    );

    // Outbound stream: the user fills, bus reads drain one word per cycle.
    // Reading it while empty returns the user's data input from the cycle before and pops nothing.
    // Every selected read of the port drains a word when one waits, so stray reads lose data.
    osp_fifo2 #(
        .W (OSP_DW + 1)
    ) u_tx_buf (
        .i_clock     (i_clock),
        .i_reset_n   (i_reset_n),
        .i_in_valid  (i_tx_valid),
        .o_in_ready  (o_tx_ready),
        .i_in_data   ({i_tx_last, i_tx_data}),
        .o_out_valid (tx_valid),
        .i_out_ready (tx_pop),
        .o_out_data  (tx_head)
    );
endmodule

// ### verilog/osp_pkg.sv
// Shared constants, address map and state codes for the on-chip slave port pair.
package osp_pkg;

    // Bus widths: the slave address, data word, byte lanes and host address.
    localparam int OSP_AW        = 8;
    localparam int OSP_DW        = 32;
    localparam int OSP_BYTE_W    = 8;
    localparam int OSP_LANES     = OSP_DW / OSP_BYTE_W;
    localparam int OSP_SYS_AW    = 16;

    // Word store of the slave: depth and index width.
    localparam int OSP_MEM_DEPTH = 16;
    localparam int OSP_MEM_IW    = 4;

    // Slave address of the streaming word port.
    localparam logic [OSP_AW-1:0] OSP_STREAM_ADDR = 8'h10;

    // Upper host address bits that select this slave.
    localparam logic [OSP_SYS_AW-OSP_AW-1:0] OSP_SLAVE_BASE_HI = 8'h00;

    // Levels of the low-active strobes and masks.
    localparam logic OSP_ON_LOW  = 1'b0;
    localparam logic OSP_OFF_LOW = 1'b1;

    // Return-valid strobe level of a fixed-latency slave.
    localparam logic OSP_RDV_IDLE = 1'b0;

    // Reset values.
    localparam logic [OSP_DW-1:0]     OSP_WORD_RST  = 32'h0000_0000;
    localparam logic [OSP_SYS_AW-1:0] OSP_ADDR_RST  = 16'h0000;
    localparam logic [OSP_LANES-1:0]  OSP_LANES_OFF = 4'hF;

    // Host sequencer states, one-hot.
    typedef enum logic [1:0] {
        OSP_IDLE = 2'h1,
        OSP_XFER = 2'h2
    } osp_state_t;

endpackage

// ### verilog/osp_bus_if.sv
// Slave port signal set joining the bus end and the peripheral end.
`timescale 1ns/10ps
interface osp_bus_if
    import osp_pkg::*;
();
    logic                 cs;
    logic [OSP_AW-1:0]    addr;
    logic                 begin_xfer;
    logic [OSP_LANES-1:0] lane_mask_low;
    logic                 read_n;
    logic                 write_n;
    logic [OSP_DW-1:0]    wdata;
    logic [OSP_DW-1:0]    rdata;
    logic                 rdata_valid;
    logic                 stall;
    logic                 sink_ready;
    logic                 source_avail;
    logic                 pkt_last;
    logic                 irq;
    logic                 reset_ask;

    // Bus module end.
    modport host (
        output cs, addr, begin_xfer, lane_mask_low, read_n, write_n, wdata,
        input  rdata, rdata_valid, stall, sink_ready, source_avail, pkt_last,
        input  irq, reset_ask
    );

    // Peripheral end.
    modport dev (
        input  cs, addr, begin_xfer, lane_mask_low, read_n, write_n, wdata,
        output rdata, rdata_valid, stall, sink_ready, source_avail, pkt_last,
        output irq, reset_ask
    );
endinterface

// ### verilog/osp_host.sv
// Bus module end: launches single-word reads and writes on the slave port.
`timescale 1ns/10ps
module osp_host
    import osp_pkg::*;
(
    input  wire logic                  i_clock,
    input  wire logic                  i_reset_n,
    osp_bus_if.host                    bus,
    input  wire logic                  i_req_valid,
    input  wire logic                  i_req_write,
    input  wire logic [OSP_SYS_AW-1:0] i_req_addr,
    input  wire logic [OSP_LANES-1:0]  i_req_lanes,
    input  wire logic [OSP_DW-1:0]     i_req_wdata,
    output logic                       o_req_ready,
    output logic                       o_rsp_valid,
    output logic [OSP_DW-1:0]          o_rsp_data,
    output logic                       o_irq,
    output logic                       o_reset_ask,
    output logic                       o_sink_ready,
    output logic                       o_source_avail,
    output logic                       o_pkt_last
);
    osp_state_t            state_ff;
    logic [OSP_SYS_AW-1:0] addr_ff;
    logic                  read_n_ff;
    logic                  write_n_ff;
    logic [OSP_LANES-1:0]  lane_n_ff;
    logic [OSP_DW-1:0]     wdata_ff;
    logic                  begin_ff;
    logic                  rsp_valid_ff;
    logic [OSP_DW-1:0]     rsp_data_ff;
    logic [4:0]            side_ff;

    // Select is decoded without a clock from the registered address.
    wire addr_hit = (addr_ff[OSP_SYS_AW-1:OSP_AW] == OSP_SLAVE_BASE_HI);
    wire strobe   = (read_n_ff == OSP_ON_LOW) || (write_n_ff == OSP_ON_LOW);
    wire sel      = addr_hit && strobe;
    wire take     = (state_ff == OSP_IDLE) && i_req_valid;
    // A stalled transfer is held unchanged until the stall drops.
    wire done     = (state_ff == OSP_XFER) && !(sel && bus.stall);
    wire is_read  = (read_n_ff == OSP_ON_LOW);

    // Strobes and mask are low active on the wire; users see high-active.
    assign bus.cs            = sel;
    assign bus.addr          = addr_ff[OSP_AW-1:0];
    assign bus.begin_xfer    = begin_ff;
    assign bus.lane_mask_low = lane_n_ff;
    assign bus.read_n        = read_n_ff;
    assign bus.write_n       = write_n_ff;
    assign bus.wdata         = wdata_ff;

    assign o_req_ready    = (state_ff == OSP_IDLE);
    assign o_rsp_valid    = rsp_valid_ff;
    assign o_rsp_data     = rsp_data_ff;
    assign o_irq          = side_ff[0];
    assign o_reset_ask    = side_ff[1];
    assign o_sink_ready   = side_ff[2];
    assign o_source_avail = side_ff[3];
    assign o_pkt_last     = side_ff[4];

    // Sequencer: launch on one edge, finish on the next unless stalled.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff <= OSP_IDLE;
        end else if (take) begin
            state_ff <= OSP_XFER;
        end else if (done) begin
            state_ff <= OSP_IDLE;
        end
    end

    // Address, mask, strobes and write word, all registered on launch.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            addr_ff    <= OSP_ADDR_RST;
            read_n_ff  <= OSP_OFF_LOW;
            write_n_ff <= OSP_OFF_LOW;
            lane_n_ff  <= OSP_LANES_OFF;
            wdata_ff   <= OSP_WORD_RST;
        end else if (take) begin
            addr_ff    <= i_req_addr;
            read_n_ff  <= i_req_write;
            write_n_ff <= !i_req_write;
            lane_n_ff  <= ~i_req_lanes;
            wdata_ff   <= i_req_wdata;
        end else if (done) begin
            read_n_ff  <= OSP_OFF_LOW;
            write_n_ff <= OSP_OFF_LOW;
        end
    end

    // First-cycle marker stands only in the launch cycle.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            begin_ff <= 1'b0;
        end else begin
            begin_ff <= take;
        end
    end

    // Read word is captured on the edge that ends the transfer.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rsp_valid_ff <= 1'b0;
            rsp_data_ff  <= OSP_WORD_RST;
        end else begin
            rsp_valid_ff <= done;
            if (done && is_read) begin
                rsp_data_ff <= bus.rdata;
            end
        end
    end

    // Peripheral status lines are registered before reaching the user.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            side_ff <= 5'h00;
        end else begin
            side_ff <= {bus.pkt_last, bus.source_avail, bus.sink_ready,
                        bus.reset_ask, bus.irq};
        end
    end
endmodule

// ### bench/osp_bus_monitor.sv
// Concurrent checks on the slave port wires between the bus end and the peripheral end.
`timescale 1ns/10ps
module osp_bus_monitor
    import osp_pkg::*;
(
    input wire logic                 i_clock,
    input wire logic                 i_reset_n,
    input wire logic                 cs,
    input wire logic [OSP_AW-1:0]    addr,
    input wire logic                 begin_xfer,
    input wire logic [OSP_LANES-1:0] lane_mask_low,
    input wire logic                 read_n,
    input wire logic                 write_n,
    input wire logic [OSP_DW-1:0]    wdata,
    input wire logic [OSP_DW-1:0]    rdata,
    input wire logic                 rdata_valid,
    input wire logic                 stall,
    input wire logic                 sink_ready,
    input wire logic                 source_avail,
    input wire logic                 pkt_last,
    input wire logic                 irq,
    input wire logic                 reset_ask
);
    // One clock domain, so clock and reset are given once for all checks.
    default clocking mon_cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);

    // Read data and lane mask are not checked here; the bench compares words end to end.
    a_rdv_never_used: assert property (rdata_valid == OSP_RDV_IDLE)
        else $error("return strobe raised by a fixed latency slave");
    a_begin_one_cycle: assert property (begin_xfer |-> (!read_n || !write_n) ##1 !begin_xfer)
        else $error("first cycle marker wrong");
    a_read_single_cycle: assert property (cs && !read_n && !stall |=> read_n)
        else $error("fundamental read not over after one cycle");
    a_stall_holds_req: assert property (cs && stall |=> cs && !write_n && $stable(addr)
        && $stable(wdata)) else $error("request changed while stalled");
    a_stall_cause_only: assert property (stall |-> cs && !write_n && !sink_ready
        && addr == OSP_STREAM_ADDR) else $error("stall without a full sink");
    a_last_with_word: assert property (pkt_last |-> source_avail)
        else $error("packet end flag without a waiting word");
    a_irq_follows_word: assert property (irq == $past(source_avail))
        else $error("service request does not track waiting word");
    a_strobes_apart: assert property (!(!read_n && !write_n))
        else $error("read and write strobes low together");
    a_sel_has_strobe: assert property (cs |-> (!read_n || !write_n))
        else $error("slave select without a strobe");

    // Main scenarios of the bench.
    cover property (cs && !read_n);
    cover property (cs && !write_n && stall);
    cover property (pkt_last && irq);
endmodule

// ### bench/onchip_bus_slave_port_test.sv
// Self-checking bench: bus end and peripheral end joined across the slave port.
`timescale 1ns/10ps
module onchip_bus_slave_port_test
    import osp_pkg::*;
;
    logic                  i_clock = 1'b0;
    logic                  i_reset_n = 1'b0;
    logic                  i_req_valid = 1'b0;
    logic                  i_req_write = 1'b0;
    logic [OSP_SYS_AW-1:0] i_req_addr = 16'h0000;
    logic [OSP_LANES-1:0]  i_req_lanes = 4'hF;
    logic [OSP_DW-1:0]     i_req_wdata = 32'h0000_0000;
    logic                  i_rx_ready = 1'b0;
    logic                  i_tx_valid = 1'b0;
    logic [OSP_DW-1:0]     i_tx_data = 32'h0000_0000;
    logic                  i_tx_last = 1'b0;
    logic                  i_reset_ask = 1'b0;
    logic                  o_req_ready, o_rsp_valid, o_irq, o_reset_ask;
    logic                  o_sink_ready, o_source_avail, o_pkt_last;
    logic                  o_rx_valid, o_tx_ready;
    logic [OSP_DW-1:0]     o_rsp_data, o_rx_data, rsp_word;
    int                    n_errors = 0;
    int                    num_checks = 0;
    int                    cycles = 0;

    osp_bus_if osp_bus_if_inst ();
    osp_host osp_host_inst (.i_clock, .i_reset_n, .bus(osp_bus_if_inst), .i_req_valid,
        .i_req_write, .i_req_addr, .i_req_lanes, .i_req_wdata, .o_req_ready, .o_rsp_valid,
        .o_rsp_data, .o_irq, .o_reset_ask, .o_sink_ready, .o_source_avail, .o_pkt_last);
    osp_dev osp_dev_inst (.i_clock, .i_reset_n, .bus(osp_bus_if_inst), .o_rx_valid,
        .i_rx_ready, .o_rx_data, .i_tx_valid, .o_tx_ready, .i_tx_data, .i_tx_last, .i_reset_ask);
    osp_bus_monitor osp_bus_monitor_inst (.i_clock, .i_reset_n, .cs(osp_bus_if_inst.cs),
        .addr(osp_bus_if_inst.addr), .begin_xfer(osp_bus_if_inst.begin_xfer),
        .lane_mask_low(osp_bus_if_inst.lane_mask_low), .read_n(osp_bus_if_inst.read_n),
        .write_n(osp_bus_if_inst.write_n), .wdata(osp_bus_if_inst.wdata),
        .rdata(osp_bus_if_inst.rdata), .rdata_valid(osp_bus_if_inst.rdata_valid),
        .stall(osp_bus_if_inst.stall), .sink_ready(osp_bus_if_inst.sink_ready),
        .source_avail(osp_bus_if_inst.source_avail), .pkt_last(osp_bus_if_inst.pkt_last),
        .irq(osp_bus_if_inst.irq), .reset_ask(osp_bus_if_inst.reset_ask));

    // Clock at 200 MHz.
    always #2.5 i_clock = ~i_clock;

    task tally_and_finish;
        if (n_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Word and flag comparisons use case equality so an unknown never matches.
    task chk32(input string nm, input logic [OSP_DW-1:0] exp, input logic [OSP_DW-1:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    task chk1(input string nm, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %b, seen %b", nm, exp, got);
        end
    endtask

    // One host request, held until taken; returns once the answer pulse is seen.
    task xfer(input logic wr, input logic [15:0] a, input logic [3:0] ln, input logic [31:0] wd);
        @(posedge i_clock);
        i_req_valid <= 1'b1;
        i_req_write <= wr;
        i_req_addr <= a;
        i_req_lanes <= ln;
        i_req_wdata <= wd;
        @(negedge i_clock);
        while (o_req_ready !== 1'b1) @(negedge i_clock);
        @(posedge i_clock);
        i_req_valid <= 1'b0;
        @(negedge i_clock);
        while (o_rsp_valid !== 1'b1) @(negedge i_clock);
        rsp_word = o_rsp_data;
    endtask

    task rd_chk(input string nm, input logic [15:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 4'hF, 32'h0000_0000);
        chk32(nm, exp, rsp_word);
    endtask

    // Peripheral stream ports: one word per valid and ready edge.
    task tx_push(input logic [31:0] d, input logic last);
        @(posedge i_clock);
        i_tx_valid <= 1'b1;
        i_tx_data <= d;
        i_tx_last <= last;
        @(negedge i_clock);
        while (o_tx_ready !== 1'b1) @(negedge i_clock);
        @(posedge i_clock);
        i_tx_valid <= 1'b0;
    endtask

    task rx_pop(input logic [31:0] exp);
        @(posedge i_clock);
        i_rx_ready <= 1'b1;
        @(negedge i_clock);
        while (o_rx_valid !== 1'b1) @(negedge i_clock);
        chk32("rx word", exp, o_rx_data);
        @(posedge i_clock);
        i_rx_ready <= 1'b0;
    endtask

    // A hang ends the run as a failure.
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_errors = n_errors + 1;
            tally_and_finish;
        end
    end

    // Main sequence; the third stream write meets a full sink and must wait, not be lost.
    initial begin
        repeat (12) @(posedge i_clock);
        i_reset_n <= 1'b1;
        @(negedge i_clock);
        chk1("req_ready", 1'b1, o_req_ready);
        chk1("sink_ready reset", 1'b0, o_sink_ready);
        @(negedge i_clock);
        chk1("sink_ready", 1'b1, o_sink_ready);
        xfer(1'b1, 16'h0003, 4'hF, 32'h1234_5678);
        rd_chk("word 3", 16'h0003, 32'h1234_5678);
        xfer(1'b1, 16'h000F, 4'hF, 32'hFFFF_FFFF);
        xfer(1'b1, 16'h000F, 4'h5, 32'h0000_0000);
        rd_chk("masked word", 16'h000F, 32'hFF00_FF00);
        xfer(1'b1, 16'h0103, 4'hF, 32'hDEAD_BEEF);
        rd_chk("unselected", 16'h0003, 32'h1234_5678);
        xfer(1'b1, 16'h0010, 4'hF, 32'hA000_0001);
        xfer(1'b1, 16'h0010, 4'hF, 32'hA000_0002);
        fork
            xfer(1'b1, 16'h0010, 4'hF, 32'hA000_0003);
            begin
                repeat (6) @(negedge i_clock);
                chk1("sink full", 1'b0, o_sink_ready);
                chk1("stalled rsp", 1'b0, o_rsp_valid);
                rx_pop(32'hA000_0001);
                rx_pop(32'hA000_0002);
                rx_pop(32'hA000_0003);
            end
        join
        @(negedge i_clock);
        chk1("rx_valid", 1'b0, o_rx_valid);
        tx_push(32'hB000_0001, 1'b0);
        tx_push(32'hB000_0002, 1'b1);
        repeat (3) @(negedge i_clock);
        chk1("source_avail", 1'b1, o_source_avail);
        chk1("irq", 1'b1, o_irq);
        chk1("pkt_last", 1'b0, o_pkt_last);
        chk1("tx_ready", 1'b0, o_tx_ready);
        rd_chk("stream 1", 16'h0010, 32'hB000_0001);
        repeat (2) @(negedge i_clock);
        chk1("pkt_last", 1'b1, o_pkt_last);
        rd_chk("stream 2", 16'h0010, 32'hB000_0002);
        repeat (3) @(negedge i_clock);
        chk1("source_avail", 1'b0, o_source_avail);
        chk1("irq", 1'b0, o_irq);
        @(posedge i_clock);
        i_reset_ask <= 1'b1;
        repeat (3) @(negedge i_clock);
        chk1("reset_ask", 1'b1, o_reset_ask);
        @(posedge i_clock);
        i_reset_ask <= 1'b0;
        repeat (3) @(negedge i_clock);
        chk1("reset_ask", 1'b0, o_reset_ask);
        tally_and_finish;
    end
endmodule
